// ==== rtl/dec_regs.svh ====
/*
 Register offsets, field positions, reset values and op codes of the
 drawing engine command block. Assumes byte addresses on a 16-bit bus address.
*/
`ifndef DEC_REGS_SVH
`define DEC_REGS_SVH
// ==========================================
// Offsets
`define DEC_OFS_DEST_X   16'h8ee8
`define DEC_OFS_ERR      16'h92e8
`define DEC_OFS_MAJ      16'h96e8
`define DEC_OFS_STAT     16'h9ae8
`define DEC_OFS_STROKE   16'h9ee8
`define DEC_OFS_BKGD     16'ha2e8
`define DEC_OFS_MODE     16'hbef0
// ==========================================
// Command fields
`define DEC_CMD_DIR      0
`define DEC_CMD_PXMD     1
`define DEC_CMD_LASTOFF  2
`define DEC_CMD_GEOM     3
`define DEC_CMD_DRAW     4
`define DEC_CMD_DIR_LO   5
`define DEC_CMD_WAIT     8
`define DEC_CMD_BUS16    9
`define DEC_CMD_SWAP     12
`define DEC_CMD_OP_LO    13
// ==========================================
// Op codes
`define DEC_OP_NOP       3'h0
`define DEC_OP_LINE      3'h1
`define DEC_OP_RECT      3'h2
`define DEC_OP_BLT       3'h6
`define DEC_OP_PAT       3'h7
// ==========================================
// Widths, reset values and mode register bits
`define DEC_W_COORD      12
`define DEC_W_STEP       14
`define DEC_RST_16       16'h0000
`define DEC_RST_32       32'h0000_0000
`define DEC_MODE_W32     0
`define DEC_MODE_FLAG    1
`endif

// ==== rtl/dec_pkg.sv ====
/*
 Types of the drawing engine command block.
 Assumes dec_regs.svh supplies the numeric constants.
*/
package dec_pkg;
	typedef enum logic [1:0] {dec_idle, dec_run} dec_state_type;

	typedef struct packed {
		logic        is_stroke;
		logic [15:0] data;
	} dec_entry_type;

	typedef struct packed {
		logic [2:0] op;
		logic       swap;
		logic       bus16;
		logic       host_wait;
		logic [2:0] dir;
		logic       draw;
		logic       geom;
		logic       last_off;
		logic       pix_mode;
		logic       write_dir;
	} dec_cmd_type;

	typedef struct packed {
		logic       valid;
		logic       draw;
		logic [2:0] dir;
		logic       new_line;
		logic [2:0] pat_col;
		logic [2:0] pat_row;
	} dec_pixel_type;
endpackage

// ==== rtl/dec_top.sv ====
/*
 Drawing engine command and parameter registers with an eight slot command
 queue and a pixel sequencer. Assumes a classic Wishbone master, and that the
 pixel datapath consumes pixel_out and pulses pix_xfer_done per host datum.
*/
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "dec_regs.svh"

module dec_top #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [15:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Datapath side
	input  wire logic                 pix_xfer_done,
	input  wire logic [11:0]          minor_axis_count,
	output dec_pkg::dec_pixel_type    pixel_out,
	output dec_pkg::dec_cmd_type      cmd_active,
	output logic                      read_data_ready,
	// Parameter registers
	output logic [31:0]               background_colour,
	output logic [13:0]               dest_x_diagonal_step,
	output logic [13:0]               line_error_term,
	output logic [11:0]               major_axis_count
);
	localparam int CW = $clog2(DEPTH + 1);

	function automatic logic [15:0] apply_sel(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] sel);
		apply_sel = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic [7:0] therm(input logic [CW-1:0] n);
		logic [8:0] t;
		t = (9'h001 << n) - 9'h001;
		therm = t[7:0];
	endfunction

	function automatic dec_pkg::dec_cmd_type decode(input logic [15:0] d);
		decode.op        = d[`DEC_CMD_OP_LO +: 3];
		decode.swap      = d[`DEC_CMD_SWAP];
		decode.bus16     = d[`DEC_CMD_BUS16];
		decode.host_wait = d[`DEC_CMD_WAIT];
		decode.dir       = d[`DEC_CMD_DIR_LO +: 3];
		decode.draw      = d[`DEC_CMD_DRAW];
		decode.geom      = d[`DEC_CMD_GEOM];
		decode.last_off  = d[`DEC_CMD_LASTOFF];
		decode.pix_mode  = d[`DEC_CMD_PXMD];
		decode.write_dir = d[`DEC_CMD_DIR];
	endfunction

	// ==========================================
	// Bus decode
	logic                  req;
	logic                  hit_stat;
	logic                  hit_stroke;
	logic                  queue_write;
	logic                  full;
	logic                  take;
	logic                  wr;
	logic                  rd;
	logic [1:0]            mode;
	logic [15:0]           engine_status;

	assign req         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit_stat    = wb_adr_i == `DEC_OFS_STAT;
	assign hit_stroke  = wb_adr_i == `DEC_OFS_STROKE;
	assign queue_write = wb_we_i & (hit_stat | hit_stroke);
	// A full queue withholds ack, so the host stalls instead of losing a command
	assign take        = req & ~(queue_write & full);
	assign wr          = take & wb_we_i;
	assign rd          = take & ~wb_we_i;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= take;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wb_dat_o <= `DEC_RST_32;
		else if (rd)
		begin
			unique case (wb_adr_i)
				`DEC_OFS_DEST_X: wb_dat_o <= {18'h0, dest_x_diagonal_step};
				`DEC_OFS_ERR:    wb_dat_o <= {18'h0, line_error_term};
				`DEC_OFS_MAJ:    wb_dat_o <= {20'h0, major_axis_count};
				`DEC_OFS_STAT:   wb_dat_o <= {16'h0, engine_status};
				`DEC_OFS_MODE:   wb_dat_o <= {30'h0, mode};
				`DEC_OFS_BKGD:
				begin
					if (mode[`DEC_MODE_W32])
						wb_dat_o <= {16'h0, mode[`DEC_MODE_FLAG] ? background_colour[31:16] :
							background_colour[15:0]};
					else
						wb_dat_o <= background_colour;
				end
				default:         wb_dat_o <= `DEC_RST_32;
			endcase
		end
	end

	// ==========================================
	// Parameter registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dest_x_diagonal_step <= 14'h0000;
		else if (wr && wb_adr_i == `DEC_OFS_DEST_X)
			dest_x_diagonal_step <= 14'(apply_sel({2'h0, dest_x_diagonal_step}, wb_dat_i[15:0],
				wb_sel_i[1:0]));
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			line_error_term <= 14'h0000;
		else if (wr && wb_adr_i == `DEC_OFS_ERR)
			line_error_term <= 14'(apply_sel({2'h0, line_error_term}, wb_dat_i[15:0],
				wb_sel_i[1:0]));
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			major_axis_count <= 12'h000;
		else if (wr && wb_adr_i == `DEC_OFS_MAJ)
			major_axis_count <= 12'(apply_sel({4'h0, major_axis_count}, wb_dat_i[15:0],
				wb_sel_i[1:0]));
	end

	// Mode bit 0 is 32 bpp, bit 1 the half word select flag
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			mode <= 2'h0;
		else if (wr && wb_adr_i == `DEC_OFS_MODE && wb_sel_i[0])
			mode <= wb_dat_i[1:0];
		else if (take && wb_adr_i == `DEC_OFS_BKGD && mode[`DEC_MODE_W32])
			mode[`DEC_MODE_FLAG] <= ~mode[`DEC_MODE_FLAG];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			background_colour <= `DEC_RST_32;
		else if (wr && wb_adr_i == `DEC_OFS_BKGD)
		begin
			if (!mode[`DEC_MODE_W32])
				background_colour <= {apply_sel(background_colour[31:16], wb_dat_i[31:16], wb_sel_i[3:2]),
					apply_sel(background_colour[15:0], wb_dat_i[15:0], wb_sel_i[1:0])};
			else if (mode[`DEC_MODE_FLAG])
				background_colour[31:16] <= apply_sel(background_colour[31:16], wb_dat_i[15:0],
					wb_sel_i[1:0]);
			else
				background_colour[15:0] <= apply_sel(background_colour[15:0], wb_dat_i[15:0],
					wb_sel_i[1:0]);
		end
	end

	// ==========================================
	// Command queue
	dec_pkg::dec_entry_type  q_mem [DEPTH];
	logic [CW-1:0]           q_cnt;
	logic [$clog2(DEPTH)-1:0] q_wp;
	logic [$clog2(DEPTH)-1:0] q_rp;
	logic                    push;
	logic                    pop;
	dec_pkg::dec_entry_type  q_head;
	dec_pkg::dec_state_type  state;

	assign full   = q_cnt == CW'(DEPTH);
	assign push   = wr & queue_write;
	assign pop    = state == dec_pkg::dec_idle && q_cnt != '0;
	assign q_head = q_mem[q_rp];

	always_ff @(posedge clk)
	begin
		if (push)
			q_mem[q_wp] <= '{is_stroke: hit_stroke, data: apply_sel(16'h0, wb_dat_i[15:0], wb_sel_i[1:0])};
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q_wp  <= '0;
			q_rp  <= '0;
			q_cnt <= '0;
		end
		else
		begin
			if (push)
				q_wp <= (q_wp == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : q_wp + 1'b1;
			if (pop)
				q_rp <= (q_rp == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : q_rp + 1'b1;
			q_cnt <= q_cnt + CW'(push) - CW'(pop);
		end
	end

	// ==========================================
	// Pixel sequencer
	logic [11:0] pcnt;
	logic [11:0] lcnt;
	logic [11:0] col;
	logic [11:0] row;
	logic [2:0]  cur_dir;
	logic        cur_draw;
	logic        vector;
	logic        second;
	logic [7:0]  second_vec;
	logic        step_ok;
	logic        last;
	logic [7:0]  first_vec;

	// Host handshake gates every pixel when waiting is on
	assign step_ok = ~cmd_active.host_wait |
		(cmd_active.write_dir ? pix_xfer_done : ~read_data_ready);
	assign last    = pcnt == 12'h000 && lcnt == 12'h000 && !second;
	// Byte order picks which vector runs first
	assign first_vec = cmd_active.swap ? q_head.data[7:0] : q_head.data[15:8];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state      <= dec_pkg::dec_idle;
			cmd_active <= '0;
			pcnt       <= 12'h000;
			lcnt       <= 12'h000;
			col        <= 12'h000;
			row        <= 12'h000;
			cur_dir    <= 3'h0;
			cur_draw   <= 1'b0;
			vector     <= 1'b0;
			second     <= 1'b0;
			second_vec <= 8'h00;
		end
		else
		begin
			unique case (state)
				dec_pkg::dec_idle:
				begin
					col <= 12'h000;
					row <= 12'h000;
					if (pop && q_head.is_stroke)
					begin
						second_vec <= cmd_active.swap ? q_head.data[15:8] : q_head.data[7:0];
						pcnt       <= {8'h00, first_vec[3:0]};
						cur_draw   <= first_vec[4];
						cur_dir    <= first_vec[7:5];
						lcnt       <= 12'h000;
						vector     <= 1'b1;
						second     <= 1'b1;
						cmd_active.host_wait <= 1'b0;
						state      <= dec_pkg::dec_run;
					end
					else if (pop)
					begin
						cmd_active <= decode(q_head.data);
						cur_dir    <= q_head.data[`DEC_CMD_DIR_LO +: 3];
						cur_draw   <= q_head.data[`DEC_CMD_DRAW];
						pcnt       <= major_axis_count;
						vector     <= 1'b0;
						second     <= 1'b0;
						unique case (q_head.data[`DEC_CMD_OP_LO +: 3])
							`DEC_OP_LINE:
							begin
								lcnt  <= 12'h000;
								state <= dec_pkg::dec_run;
							end
							`DEC_OP_RECT, `DEC_OP_BLT, `DEC_OP_PAT:
							begin
								lcnt  <= minor_axis_count;
								state <= dec_pkg::dec_run;
							end
							// Nop and reserved codes both only latch setup for strokes
							default: state <= dec_pkg::dec_idle;
						endcase
					end
				end
				dec_pkg::dec_run:
				begin
					if (step_ok)
					begin
						if (pcnt != 12'h000)
						begin
							pcnt <= pcnt - 12'h001;
							col  <= col + 12'h001;
						end
						else if (lcnt != 12'h000)
						begin
							lcnt <= lcnt - 12'h001;
							pcnt <= major_axis_count;
							col  <= 12'h000;
							row  <= row + 12'h001;
						end
						else if (second)
						begin
							second   <= 1'b0;
							pcnt     <= {8'h00, second_vec[3:0]};
							cur_draw <= second_vec[4];
							cur_dir  <= second_vec[7:5];
						end
						else
							state <= dec_pkg::dec_idle;
					end
				end
				default: state <= dec_pkg::dec_idle;
			endcase
		end
	end

	// ==========================================
	// Pixel output and read data flag
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pixel_out <= '0;
		else
		begin
			pixel_out.valid    <= state == dec_pkg::dec_run && step_ok;
			pixel_out.draw     <= cur_draw & ~(last & cmd_active.last_off &
				(vector | cmd_active.op == `DEC_OP_LINE));
			pixel_out.dir      <= cur_dir;
			pixel_out.new_line <= pcnt == major_axis_count && !vector;
			pixel_out.pat_col  <= col[2:0];
			pixel_out.pat_row  <= row[2:0];
		end
	end

	// Set wins over the host's clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			read_data_ready <= 1'b0;
		else if (state == dec_pkg::dec_run && cmd_active.host_wait && !cmd_active.write_dir && step_ok)
			read_data_ready <= 1'b1;
		else if (pix_xfer_done)
			read_data_ready <= 1'b0;
	end

	// ==========================================
	// Status word
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			engine_status <= `DEC_RST_16;
		else
			engine_status <= {5'h00, q_cnt == '0, state != dec_pkg::dec_idle || pop,
				read_data_ready, therm(q_cnt)};
	end
endmodule

// ==== tb/dec_top_properties.sv ====
/*
 Bus and status properties of the drawing engine command block.
 Assumes binding onto dec_top and its single clock domain.
*/
`timescale 1ns/1ps
`include "dec_regs.svh"

module dec_top_properties #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     nrst,
	// Wishbone
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_we_i,
	input wire logic [15:0]              wb_adr_i,
	input wire logic [3:0]               wb_sel_i,
	input wire logic [31:0]              wb_dat_i,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     wb_ack_o,
	// Datapath and registers
	input wire logic                     pix_xfer_done,
	input wire logic [11:0]              minor_axis_count,
	input wire dec_pkg::dec_pixel_type   pixel_out,
	input wire dec_pkg::dec_cmd_type     cmd_active,
	input wire logic                     read_data_ready,
	input wire logic [31:0]              background_colour,
	input wire logic [13:0]              dest_x_diagonal_step,
	input wire logic [13:0]              line_error_term,
	input wire logic [11:0]              major_axis_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// Sequences
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wr(a);
		wb_ack_o && wb_we_i && wb_adr_i == a && wb_sel_i[1:0] == 2'b11;
	endsequence
	sequence s_stat_rd;
		wb_ack_o && !wb_we_i && wb_adr_i == `DEC_OFS_STAT;
	endsequence
	// ==========================================
	// Properties
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	chk_ack_latency: assert property (s_req ##0 !(wb_we_i && (wb_adr_i == `DEC_OFS_STAT ||
		wb_adr_i == `DEC_OFS_STROKE)) |=> wb_ack_o) else $error("ack late");
	chk_unmapped_zero: assert property (s_req ##0 !wb_we_i && !(wb_adr_i inside {`DEC_OFS_DEST_X, `DEC_OFS_ERR,
		`DEC_OFS_MAJ, `DEC_OFS_STAT, `DEC_OFS_STROKE, `DEC_OFS_BKGD, `DEC_OFS_MODE}) |=> wb_ack_o && wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_diag_write: assert property (s_wr(`DEC_OFS_DEST_X) |=> dest_x_diagonal_step == $past(wb_dat_i[13:0]))
		else $error("dest x not written");
	chk_err_write: assert property (s_wr(`DEC_OFS_ERR) |=> line_error_term == $past(wb_dat_i[13:0]))
		else $error("error term not written");
	chk_major_write: assert property (s_wr(`DEC_OFS_MAJ) |=> major_axis_count == $past(wb_dat_i[11:0]))
		else $error("major count not written");
	chk_status_code: assert property (s_stat_rd |-> ((wb_dat_o[7:0] + 8'h01) & wb_dat_o[7:0]) == 8'h00
		&& wb_dat_o[10] == (wb_dat_o[7:0] == 8'h00)) else $error("status code malformed");
	chk_wait_pixel: assert property (pixel_out.valid && cmd_active.host_wait && cmd_active.write_dir
		&& cmd_active.op != `DEC_OP_NOP |=> !pixel_out.valid) else $error("pixel without host datum");
endmodule

bind dec_top dec_top_properties #(.DEPTH(DEPTH)) u_chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_xfer_done(pix_xfer_done), .minor_axis_count(minor_axis_count),
	.pixel_out(pixel_out), .cmd_active(cmd_active), .read_data_ready(read_data_ready),
	.background_colour(background_colour), .dest_x_diagonal_step(dest_x_diagonal_step),
	.line_error_term(line_error_term), .major_axis_count(major_axis_count));

// ==== tb/dec_pix_host.sv ====
/*
 Model of the host moving pixel data through the port.
 Keeps a write datum ready on its own and answers each read pixel;
 assumes one valid pulse per pixel; stall holds the datum back.
*/
`timescale 1ns/1ps

module dec_pix_host (
	// Clock and reset
	input wire logic  clk,
	input wire logic  nrst,
	// Engine side
	input wire logic  pix_valid,
	input wire logic  stall,
	input wire logic  slow,
	output logic      pix_xfer_done
);
	logic [3:0] wait_cnt;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_cnt <= 4'h0;
			pix_xfer_done <= 1'b0;
		end
		else
		begin
			pix_xfer_done <= 1'b0;
			// Writes must not wait on a pixel, or the engine and host deadlock
			if (pix_valid || wait_cnt == 4'h0)
				wait_cnt <= slow ? 4'h6 : 4'h1;
			else if (wait_cnt != 4'h0 && !stall)
			begin
				wait_cnt <= wait_cnt - 4'h1;
				pix_xfer_done <= (wait_cnt == 4'h1);
			end
		end
	end
endmodule

// ==== tb/dec_top_tb_top.sv ====
/*
 Self-checking bench of the drawing engine command block.
 Assumes the design, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "dec_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module dec_top_tb_top;
	logic                    clk, nrst, cyc, stb, we, ack, stall, slow, done, rdr, last_draw;
	logic [15:0]             adr, c, lo, hi;
	logic [3:0]              sel;
	logic [31:0]             wdat, rd, rd_o, bg;
	logic [13:0]             dxs, err;
	logic [11:0]             maj, minc;
	logic [2:0]              first_dir;
	dec_pkg::dec_pixel_type  pix;
	dec_pkg::dec_cmd_type    act;
	int                      fails, samples_checked, pix_n, seed, dx, dy, mn, mx, xi, n;

	dec_top #(.DEPTH(8)) uut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
		.pix_xfer_done(done), .minor_axis_count(minc), .pixel_out(pix), .cmd_active(act),
		.read_data_ready(rdr), .background_colour(bg), .dest_x_diagonal_step(dxs),
		.line_error_term(err), .major_axis_count(maj));
	dec_pix_host u_host (.clk(clk), .nrst(nrst), .pix_valid(pix.valid), .stall(stall), .slow(slow),
		.pix_xfer_done(done));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (pix.valid === 1'b1)
		begin
			if (pix_n == 0)
				first_dir = pix.dir;
			// Fill ops only run in the op loop, three pixels per line
			if (act.op inside {`DEC_OP_RECT, `DEC_OP_BLT, `DEC_OP_PAT})
			begin
				`CHK("pat_col", 3'(pix_n % 3), pix.pat_col)
				`CHK("pat_row", 3'(pix_n / 3), pix.pat_row)
				`CHK("new_line", pix_n % 3 == 0, pix.new_line)
			end
			pix_n++;
			last_draw = pix.draw;
		end
	end
	// ==========================================
	// Tasks
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && k < 300)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 300)
			fails++;
		rd = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// Status lags a cycle, so poll until empty and idle
	task automatic idle();
		int k;
		k = 0;
		wb(1'b0, `DEC_OFS_STAT, 32'h0);
		while (rd[10:9] !== 2'b10 && k < 400)
		begin
			wb(1'b0, `DEC_OFS_STAT, 32'h0);
			k++;
		end
		if (k >= 400)
			fails++;
	endtask

	function automatic int npix(logic [2:0] op, int m, int k);
		case (op)
			`DEC_OP_LINE: return m + 1;
			`DEC_OP_RECT, `DEC_OP_BLT, `DEC_OP_PAT: return (m + 1) * (k + 1);
			default: return 0;
		endcase
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	initial
	begin
		seed = 32'h2a0d;
		{nrst, cyc, stb, we, stall, slow} = 6'h0;
		adr = 16'h0;
		sel = 4'hf;
		wdat = 32'h0;
		minc = 12'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wb(1'b0, `DEC_OFS_STAT, 32'h0);
		`CHK("status_reset", 11'h400, rd[10:0])
		for (int i = 0; i < 4; i++)
		begin
			dx = $random(seed) & 511;
			dy = $random(seed) & 511;
			mn = dx < dy ? dx : dy;
			mx = dx < dy ? dy : dx;
			xi = $random(seed) & 1;
			wb(1'b1, `DEC_OFS_DEST_X, 2 * (mn - mx));
			wb(1'b1, `DEC_OFS_ERR, 2 * mn - mx - xi);
			wb(1'b1, `DEC_OFS_MAJ, mx);
			`CHK("diag_port", 14'(2 * (mn - mx)), dxs)
			`CHK("err_port", 14'(2 * mn - mx - xi), err)
			`CHK("major_port", 12'(mx), maj)
			wb(1'b0, `DEC_OFS_ERR, 32'h0);
			`CHK("err_term", 14'(2 * mn - mx - xi), rd[13:0])
			wb(1'b0, `DEC_OFS_MAJ, 32'h0);
			`CHK("major", 12'(mx), rd[11:0])
		end
		wb(1'b1, 16'h1234, $random(seed));
		wb(1'b0, 16'h1234, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		wb(1'b1, `DEC_OFS_MAJ, 32'h2);
		for (int i = 0; i < 16; i++)
		begin
			c = 16'($random(seed));
			c[15:13] = i[2:0];
			c[11:8] &= 4'h2;
			c[2] = i[3];
			minc <= 12'($random(seed) & 3);
			@(posedge clk);
			pix_n = 0;
			wb(1'b1, `DEC_OFS_STAT, {16'h0, c});
			idle();
			`CHK("pixels", npix(c[15:13], 2, minc), pix_n)
			`CHK("cmd_fields", {c[15:12], c[9:0]}, act)
			if (npix(c[15:13], 2, minc) > 0)
				`CHK("last_draw", c[4] & !(c[15:13] == `DEC_OP_LINE && c[2]), last_draw)
		end
		stall <= 1'b1;
		wb(1'b1, `DEC_OFS_STAT, 32'h2111);
		repeat (3) wb(1'b1, `DEC_OFS_STAT, 32'h0);
		wb(1'b0, `DEC_OFS_STAT, 32'h0);
		`CHK("status_part", 11'h207, rd[10:0])
		repeat (5) wb(1'b1, `DEC_OFS_STAT, 32'h0);
		wb(1'b0, `DEC_OFS_STAT, 32'h0);
		`CHK("status_full", 11'h2ff, rd[10:0])
		slow <= 1'b1;
		stall <= 1'b0;
		idle();
		`CHK("status_done", 11'h400, rd[10:0])
		stall <= 1'b1;
		pix_n = 0;
		wb(1'b1, `DEC_OFS_STAT, 32'h2110);
		for (n = 0; n < 50 && pix_n == 0; n++)
			@(posedge clk);
		@(posedge clk);
		`CHK("rd_ready", 1'b1, rdr)
		wb(1'b0, `DEC_OFS_STAT, 32'h0);
		`CHK("status_rdy", 2'b11, rd[9:8])
		stall <= 1'b0;
		idle();
		for (n = 0; n < 50 && rdr !== 1'b0; n++)
			@(posedge clk);
		`CHK("rd_drained", 1'b0, rdr)
		`CHK("wait_pixels", 3, pix_n)
		lo = 16'($random(seed));
		hi = 16'($random(seed));
		wb(1'b1, `DEC_OFS_MODE, 32'h1);
		wb(1'b1, `DEC_OFS_BKGD, {16'h0, lo});
		wb(1'b1, `DEC_OFS_BKGD, {16'h0, hi});
		`CHK("bkgd_port", {hi, lo}, bg)
		wb(1'b0, `DEC_OFS_BKGD, 32'h0);
		`CHK("bkgd_lo", lo, rd[15:0])
		wb(1'b0, `DEC_OFS_BKGD, 32'h0);
		`CHK("bkgd_hi", hi, rd[15:0])
		wb(1'b0, `DEC_OFS_MODE, 32'h0);
		`CHK("half_flag", 2'b01, rd[1:0])
		for (int s = 0; s < 2; s++)
		begin
			wb(1'b1, `DEC_OFS_STAT, {19'h0, s[0], 12'h0});
			c = 16'($random(seed)) | 16'h1010;
			pix_n = 0;
			wb(1'b1, `DEC_OFS_STROKE, {16'h0, c});
			idle();
			`CHK("stroke_n", c[3:0] + c[11:8] + 2, pix_n)
			`CHK("stroke_dir", s ? c[7:5] : c[15:13], first_dir)
		end
		conclude();
	end

	initial
	begin
		repeat (50000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule
